/* File: hdl/uitm_cfg.svh */
/*
 holds offsets, field positions, reset values and fixed codes of the
 upstream traffic-class window map; assumes byte addresses on an 8-bit apb paddr
*/
`ifndef UITM_CFG_SVH
`define UITM_CFG_SVH

`define UITM_PADDR_W      8
`define UITM_OFF_CAP      8'h00
`define UITM_OFF_ISO_CTRL 8'h04
`define UITM_OFF_W0_CTRL  8'h08
`define UITM_OFF_W0_BASE  8'h0c
`define UITM_OFF_W0_LIMIT 8'h10
`define UITM_OFF_W1_CTRL  8'h14
`define UITM_OFF_W1_BASE  8'h18
`define UITM_OFF_W1_LIMIT 8'h1c
`define UITM_OFF_W2_CTRL  8'h20
`define UITM_OFF_W2_BASE  8'h24
`define UITM_OFF_STATUS   8'h38

`define UITM_SEL_CAP      4'h0
`define UITM_SEL_ISO_CTRL 4'h1
`define UITM_SEL_W0_CTRL  4'h2
`define UITM_SEL_W0_BASE  4'h3
`define UITM_SEL_W0_LIMIT 4'h4
`define UITM_SEL_W1_CTRL  4'h5
`define UITM_SEL_W1_BASE  4'h6
`define UITM_SEL_W1_LIMIT 4'h7
`define UITM_SEL_W2_CTRL  4'h8
`define UITM_SEL_W2_BASE  4'h9
`define UITM_SEL_STATUS   4'ha
`define UITM_SEL_NONE     4'hf

`define UITM_CTRL_EN_BIT  0
`define UITM_CTRL_TC_LSB  1
`define UITM_CTRL_TC_MSB  3
`define UITM_GEN_EN_BIT   0
`define UITM_STAT_TC_LSB  0
`define UITM_STAT_HIT_LSB 4

`define UITM_CTRL_RST     4'h0
`define UITM_ADDR_RST     32'h0000_0000
`define UITM_WIN_COUNT    4'h4
`define UITM_TC_DEFAULT   3'h0

`endif

/* File: hdl/uitm_pkg.sv */
/*
 types of the upstream traffic-class window map;
 assumes the constants of uitm_cfg.svh for values
*/
package uitm_pkg;

   typedef struct packed {
      logic [2:0] tc;
      logic       en;
   } uitm_ctrl_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } uitm_req_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] tc;
      logic [2:0] hit;
   } uitm_res_t;

   typedef struct packed {
      uitm_ctrl_t [2:0]        ctrl;
      logic       [2:0][31:0]  base;
      logic       [1:0][31:0]  limit;
      logic                    gen;
      logic       [31:0]       prdata;
      logic                    pready;
      logic                    pslverr;
      uitm_res_t               res;
   } uitm_state_t;

endpackage

/* File: hdl/uitm_map.sv */
/*
 apb register bank and address match that gives upstream memory transactions
 a traffic class from three programmable windows.
 assumes an apb4 master on sys_clk, and an upstream path on the same clock
 that also supplies the upper bound of window 2.
*/
// What this block does
// RL1 - control register bits 15:4 always read back as zero
// RL2 - control bits 3:1 hold a writable traffic class, reset to zero
// RL3 - a window with its enable bit clear never changes traffic class
// RL4 - enabled window maps hitting upstream addresses to its traffic class
// RL5 - each window has a 32-bit writable base, reset to zero
// RL6 - each window has a 32-bit writable limit, reset to zero; window 2 here takes its limit from the win2_limit input
// RL7 - base and limit store any value even while window disabled
// RL8 - window 0 control, base, limit sit at 08h, 0ch, 10h
// RL9 - window 1 control, base, limit sit at 14h, 18h, 1ch
// RL10 - window 2 control and base sit at 20h and 24h
// RL11 - control registers are 16 bits and clear to zero on reset
// RL12 - global enable clear forces class 0, set permits other classes
// RL13 - read-only capability field reports four windows as 0100b
// RL14 - address inside window when base <= address <= limit
// RL15 - lowest-numbered matching window wins, no match gives class 0
`timescale 1ns/10ps
`include "uitm_cfg.svh"

module uitm_map #(
   parameter logic [3:0] WIN_COUNT = `UITM_WIN_COUNT
) (
   input  wire logic                      sys_clk,
   input  wire logic                      nrst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`UITM_PADDR_W-1:0]  paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [31:0]               win2_limit,
   input  uitm_pkg::uitm_req_t            up_req,
   output uitm_pkg::uitm_res_t            up_res
);

   // the capability field may not report fewer windows than are built here
   if (WIN_COUNT < 4'h3) begin : g_bad_count
      $error("uitm_map: window count below the three windows built here");
   end

   uitm_pkg::uitm_state_t q;
   uitm_pkg::uitm_state_t d;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] wdat,
      input logic [3:0]  strb
   );
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wdat[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // inclusive bounds on both ends
   function automatic logic in_window(
      input logic [31:0] addr,
      input logic [31:0] lo,
      input logic [31:0] hi
   );
      return (addr >= lo) && (addr <= hi); // see RL14
   endfunction

   // control register image, upper bits zero
   function automatic logic [31:0] ctrl_word(input uitm_pkg::uitm_ctrl_t c);
      logic [31:0] r;
      r = 32'h0000_0000; // see RL1
      r[`UITM_CTRL_TC_MSB:`UITM_CTRL_TC_LSB] = c.tc; // see RL2
      r[`UITM_CTRL_EN_BIT] = c.en; // see RL3
      return r;
   endfunction

   // write one control register from the low byte only
   function automatic uitm_pkg::uitm_ctrl_t ctrl_wr(
      input uitm_pkg::uitm_ctrl_t c,
      input logic [31:0]          wdat,
      input logic [3:0]           strb
   );
      logic [31:0] m;
      uitm_pkg::uitm_ctrl_t r;
      m = merge(ctrl_word(c), wdat, strb);
      r.tc = m[`UITM_CTRL_TC_MSB:`UITM_CTRL_TC_LSB]; // see RL2
      r.en = m[`UITM_CTRL_EN_BIT]; // see RL3
      return r;
   endfunction

   // register index of a bus address, shared by read and write decode
   function automatic logic [3:0] reg_sel(input logic [`UITM_PADDR_W-1:0] a);
      logic [3:0] s;
      s = `UITM_SEL_NONE;
      if (a == `UITM_OFF_CAP) begin
         s = `UITM_SEL_CAP;
      end else if (a == `UITM_OFF_ISO_CTRL) begin
         s = `UITM_SEL_ISO_CTRL;
      end else if (a == `UITM_OFF_W0_CTRL) begin
         s = `UITM_SEL_W0_CTRL; // see RL8
      end else if (a == `UITM_OFF_W0_BASE) begin
         s = `UITM_SEL_W0_BASE; // see RL8
      end else if (a == `UITM_OFF_W0_LIMIT) begin
         s = `UITM_SEL_W0_LIMIT; // see RL8
      end else if (a == `UITM_OFF_W1_CTRL) begin
         s = `UITM_SEL_W1_CTRL; // see RL9
      end else if (a == `UITM_OFF_W1_BASE) begin
         s = `UITM_SEL_W1_BASE; // see RL9
      end else if (a == `UITM_OFF_W1_LIMIT) begin
         s = `UITM_SEL_W1_LIMIT; // see RL9
      end else if (a == `UITM_OFF_W2_CTRL) begin
         s = `UITM_SEL_W2_CTRL; // see RL10
      end else if (a == `UITM_OFF_W2_BASE) begin
         s = `UITM_SEL_W2_BASE; // see RL10
      end else if (a == `UITM_OFF_STATUS) begin
         s = `UITM_SEL_STATUS;
      end
      return s;
   endfunction

   logic [31:0] lim [3];
   logic [3:0]  sel;
   logic [2:0]  hit;
   logic [2:0]  tc_sel;
   logic        rd_hit;
   logic [31:0] rd_data;

   always_comb begin
      lim[0] = q.limit[0];
      lim[1] = q.limit[1];
      lim[2] = win2_limit;
   end

   // per-window match
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_win
         assign hit[gi] = q.ctrl[gi].en && in_window(up_req.addr, q.base[gi], lim[gi]); // see RL3 RL4
      end
   endgenerate

   // lowest-numbered hit wins, global enable gates all mapping
   always_comb begin
      tc_sel = `UITM_TC_DEFAULT; // see RL15
      if (q.gen) begin // see RL12
         if (hit[0]) begin
            tc_sel = q.ctrl[0].tc; // see RL4 RL15
         end else if (hit[1]) begin
            tc_sel = q.ctrl[1].tc;
         end else if (hit[2]) begin
            tc_sel = q.ctrl[2].tc;
         end
      end
   end

   // read decode
   always_comb begin
      sel     = reg_sel(paddr);
      rd_hit  = (sel != `UITM_SEL_NONE);
      rd_data = 32'h0000_0000;
      if (sel == `UITM_SEL_CAP) begin
         rd_data[3:0] = WIN_COUNT; // see RL13
      end else if (sel == `UITM_SEL_ISO_CTRL) begin
         rd_data[`UITM_GEN_EN_BIT] = q.gen; // see RL12
      end else if (sel == `UITM_SEL_W0_CTRL) begin
         rd_data = ctrl_word(q.ctrl[0]); // see RL8 RL1
      end else if (sel == `UITM_SEL_W0_BASE) begin
         rd_data = q.base[0]; // see RL8 RL7
      end else if (sel == `UITM_SEL_W0_LIMIT) begin
         rd_data = q.limit[0]; // see RL8 RL7
      end else if (sel == `UITM_SEL_W1_CTRL) begin
         rd_data = ctrl_word(q.ctrl[1]); // see RL9 RL1
      end else if (sel == `UITM_SEL_W1_BASE) begin
         rd_data = q.base[1]; // see RL9
      end else if (sel == `UITM_SEL_W1_LIMIT) begin
         rd_data = q.limit[1]; // see RL9
      end else if (sel == `UITM_SEL_W2_CTRL) begin
         rd_data = ctrl_word(q.ctrl[2]); // see RL10 RL1
      end else if (sel == `UITM_SEL_W2_BASE) begin
         rd_data = q.base[2]; // see RL10
      end else if (sel == `UITM_SEL_STATUS) begin
         rd_data[`UITM_STAT_TC_LSB +: 3]  = q.res.tc;
         rd_data[`UITM_STAT_HIT_LSB +: 3] = q.res.hit;
      end
   end

   // next state
   always_comb begin
      d         = q;
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      // setup phase: answer is ready in the following access cycle
      if (psel && !penable) begin
         d.pready  = 1'b1;
         d.pslverr = !rd_hit;
         if (!pwrite) begin
            d.prdata = rd_data;
         end
      end
      // access phase with ready: the write takes effect here only
      if (psel && penable && q.pready && pwrite) begin
         if (sel == `UITM_SEL_ISO_CTRL) begin
            if (pstrb[0]) begin
               d.gen = pwdata[`UITM_GEN_EN_BIT]; // see RL12
            end
         end else if (sel == `UITM_SEL_W0_CTRL) begin
            d.ctrl[0] = ctrl_wr(q.ctrl[0], pwdata, pstrb); // see RL8 RL2
         end else if (sel == `UITM_SEL_W0_BASE) begin
            d.base[0] = merge(q.base[0], pwdata, pstrb); // see RL5 RL7 RL8
         end else if (sel == `UITM_SEL_W0_LIMIT) begin
            d.limit[0] = merge(q.limit[0], pwdata, pstrb); // see RL6 RL7 RL8
         end else if (sel == `UITM_SEL_W1_CTRL) begin
            d.ctrl[1] = ctrl_wr(q.ctrl[1], pwdata, pstrb); // see RL9 RL2
         end else if (sel == `UITM_SEL_W1_BASE) begin
            d.base[1] = merge(q.base[1], pwdata, pstrb); // see RL5 RL9
         end else if (sel == `UITM_SEL_W1_LIMIT) begin
            d.limit[1] = merge(q.limit[1], pwdata, pstrb); // see RL6 RL9
         end else if (sel == `UITM_SEL_W2_CTRL) begin
            d.ctrl[2] = ctrl_wr(q.ctrl[2], pwdata, pstrb); // see RL10 RL2
         end else if (sel == `UITM_SEL_W2_BASE) begin
            d.base[2] = merge(q.base[2], pwdata, pstrb); // see RL5 RL10
         end
      end
      // lookup result one cycle after the request
      d.res.valid = up_req.valid;
      if (up_req.valid) begin
         d.res.tc  = tc_sel; // see RL4 RL12 RL15
         d.res.hit = hit;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 3; i++) begin
            q.ctrl[i] <= `UITM_CTRL_RST; // see RL11
            q.base[i] <= `UITM_ADDR_RST; // see RL5
         end
         q.limit[0] <= `UITM_ADDR_RST; // see RL6
         q.limit[1] <= `UITM_ADDR_RST;
         q.gen      <= 1'b0;
         q.prdata   <= 32'h0000_0000;
         q.pready   <= 1'b0;
         q.pslverr  <= 1'b0;
         q.res      <= '0;
      end else begin
         q <= d;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;
   assign up_res  = q.res;

endmodule

/* File: tb/uitm_map_props.sv */
/* port checker of uitm_map
   assumes one clock and the bind below */
`timescale 1ns/10ps
module uitm_map_props (
   input wire logic          sys_clk,
   input wire logic          nrst,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [7:0]    paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [3:0]    pstrb,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic [31:0]   win2_limit,
   input uitm_pkg::uitm_req_t up_req,
   input uitm_pkg::uitm_res_t up_res
);
   logic gen_q;
   logic en0_q;
   wire  wr = psel && penable && pready && pwrite && pstrb[0];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gen_q <= 1'b0;
         en0_q <= 1'b0;
      end else if (wr) begin
         if (paddr == 8'h04) gen_q <= pwdata[0];
         if (paddr == 8'h08) en0_q <= pwdata[0];
      end
   end
   sequence s_setup; psel && !penable; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   chk_one_access: assert property (s_setup |=> s_answer)
      else $error("access not answered in one cycle");
   chk_rsvd_zero: assert property (pready && !pwrite && paddr inside {8'h08, 8'h14, 8'h20}
      |-> prdata[31:4] == 28'h0) else $error("control reserved bits set");
   chk_mapped_ok: assert property (pready && paddr inside {8'h08, 8'h0c, 8'h10, 8'h14,
      8'h18, 8'h1c, 8'h20, 8'h24} |-> !pslverr) else $error("mapped register refused");
   chk_gen_off: assert property (up_req.valid && !gen_q |=> up_res.tc == 3'h0)
      else $error("class given while global enable off");
   chk_nohit_tc: assert property (up_res.valid && up_res.hit == 3'h0 |-> up_res.tc == 3'h0)
      else $error("class given without hit");
   chk_w2_above: assert property (up_req.valid && up_req.addr > win2_limit |=> !up_res.hit[2])
      else $error("window 2 hit above limit");
   chk_w0_off: assert property (up_req.valid && !en0_q |=> !up_res.hit[0])
      else $error("disabled window 0 hit");
   chk_res_lat: assert property (up_res.valid == $past(up_req.valid))
      else $error("lookup result not one cycle late");
   chk_reset_out: assert property ($rose(nrst) |-> !pready && prdata == 32'h0 && up_res == '0)
      else $error("outputs not clear after reset");
endmodule
bind uitm_map uitm_map_props i_props (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .win2_limit(win2_limit),
   .up_req(up_req), .up_res(up_res));

/* File: tb/uitm_map_bench.sv */
/* apb register and lookup tests of uitm_map
   assumes uitm_map_props bound to the design */
`timescale 1ns/10ps
module uitm_map_bench;
   logic                sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, win2_limit, rd;
   logic [3:0]          pstrb;
   uitm_pkg::uitm_req_t up_req;
   uitm_pkg::uitm_res_t up_res;
   int                  n_fail, n_checks, cyc;
   logic [7:0]          offs [8] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
   logic [39:0]         cfg [8] = '{40'h0c_0000_1000, 40'h10_0000_1fff, 40'h18_0000_1800,
      40'h1c_0000_2fff, 40'h24_0000_3000, 40'h08_0000_0007, 40'h14_0000_000b, 40'h20_0000_000d};
   logic [34:0]         lk [9] = '{35'h0_0000_0fff, 35'h3_0000_1000, 35'h3_0000_1800,
      35'h3_0000_1fff, 35'h5_0000_2000, 35'h5_0000_2fff, 35'h6_0000_3000, 35'h6_0000_3fff,
      35'h0_0000_4000};
   uitm_map i_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .win2_limit(win2_limit), .up_req(up_req),
      .up_res(up_res));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
   end
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic look(input logic [31:0] a, input logic [2:0] e);
      @(posedge sys_clk);
      up_req <= {1'b1, a};
      @(posedge sys_clk);
      up_req.valid <= 1'b0;
      @(posedge sys_clk);
      check(33'({up_res.valid, up_res.tc}), 33'({1'b1, e}));
   endtask
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, win2_limit, up_req} = '0;
      pstrb = 4'hf;
      n_fail = 0;
      n_checks = 0;
      fork
         begin
            repeat (3) @(posedge sys_clk);
            nrst <= 1'b1;
            foreach (offs[i]) begin
               apb(1'b0, offs[i], 32'h0);
               check({err, rd}, 33'h0);
            end
            foreach (offs[i]) apb(1'b1, offs[i], {offs[i], 24'h5a5a5f});
            foreach (offs[i]) begin
               apb(1'b0, offs[i], 32'h0);
               check({err, rd}, (i % 3 == 0) ? 33'hf : {1'b0, offs[i], 24'h5a5a5f});
            end
            apb(1'b0, 8'h3c, 32'h0);
            check({err, rd}, 33'h1_0000_0000);
            apb(1'b0, 8'h00, 32'h0);
            check({err, rd}, 33'h4);
            foreach (cfg[i]) apb(1'b1, cfg[i][39:32], cfg[i][31:0]);
            win2_limit <= 32'h3fff;
            look(32'h1000, 3'h0);
            apb(1'b0, 8'h38, 32'h0);
            check({err, rd}, 33'h10);
            apb(1'b1, 8'h04, 32'h1);
            apb(1'b0, 8'h04, 32'h0);
            check({err, rd}, 33'h1);
            foreach (lk[i]) look(lk[i][31:0], lk[i][34:32]);
            apb(1'b1, 8'h08, 32'h6);
            look(32'h1800, 3'h5);
            apb(1'b0, 8'h38, 32'h0);
            check({err, rd}, 33'h25);
            look(32'h1000, 3'h0);
            win2_limit <= 32'h3000;
            look(32'h3001, 3'h0);
            pstrb <= 4'h2;
            apb(1'b1, 8'h18, 32'haaaa_bbcc);
            pstrb <= 4'hf;
            apb(1'b0, 8'h18, 32'h0);
            check({err, rd}, 33'h0_0000_bb00);
            nrst <= 1'b0;
            @(posedge sys_clk);
            nrst <= 1'b1;
            apb(1'b0, 8'h14, 32'h0);
            check({err, rd}, 33'h0);
            apb(1'b0, 8'h18, 32'h0);
            check({err, rd}, 33'h0);
         end
         begin
            wait (cyc == 3000);
            n_fail++;
            $display("Error t=%0t timeout", $time);
         end
      join_any
      disable fork;
      print_verdict();
   end
endmodule
